// >>> shared/flash_pkg.sv
// constants and types shared by the flash array and its controlling end
// Overview of operation
// - erase leaves every bit at one
// - erase always covers the whole segment
// - programming only clears bits, never sets
// - program by bit, byte or word
// - bench erases segment before raising bits; controller does not enforce it
// - repeated programs accumulate as bitwise and
// - controller supplies divided active timing clock
// - readable flag toggles on supply shift during program
// - bench refreshes a row by erase and rewrite; no program time limit is tracked
// - controller checks address range before operating
// - controller compares flag at start and end
package flash_pkg;
  localparam int ADDR_W      = 6;   // word address width
  localparam int DATA_W      = 16;  // word width
  localparam int SEG_W       = 3;   // words per segment = 2**SEG_W
  localparam int WORDS       = 1 << ADDR_W;
  localparam int SEG_WORDS   = 1 << SEG_W;
  localparam int CNT_W       = 8;
  // timing in ticks of the divided timing clock
  localparam logic [CNT_W-1:0] PROG_TICKS  = 8'h04;
  localparam logic [CNT_W-1:0] ERASE_TICKS = 8'h10;
  localparam logic [CNT_W-1:0] DIV_RESET   = 8'h00;
  localparam logic [CNT_W-1:0] DIV_DEFAULT = 8'h03; // divider to timing range

  typedef enum logic [1:0] {op_none, op_prog_bit, op_prog_byte, op_prog_word} prog_size_e;
  typedef enum logic [1:0] {cmd_idle, cmd_prog, cmd_erase} cmd_e;
endpackage

// >>> shared/flash_if.sv
// link between the flash array and its controller
interface flash_if;
  import flash_pkg::*;
  logic                 req;        // request strobe, one cycle
  cmd_e                 cmd;
  prog_size_e           size;
  logic [ADDR_W-1:0]    addr;
  logic [3:0]           bit_sel;    // bit index for single-bit program
  logic                 byte_sel;   // upper byte when set
  logic [DATA_W-1:0]    wdata;
  logic                 tick;       // divided timing clock pulse
  logic                 busy;
  logic                 done;
  logic [DATA_W-1:0]    rdata;
  logic                 supply_shift_flag;
  modport device (input req, cmd, size, addr, bit_sel, byte_sel, wdata, tick,
                  output busy, done, rdata, supply_shift_flag);
  modport ctrl (output req, cmd, size, addr, bit_sel, byte_sel, wdata, tick,
                input busy, done, rdata, supply_shift_flag);
endinterface

// >>> core/flash_array.sv
// flash array with segment erase, clear-only program and supply-shift flag
module flash_array (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // link to controller
  flash_if.device   link,
  // supply monitor, high when supply is out of its programming window
  input  wire logic supply_low
);
  import flash_pkg::*;

  typedef struct packed {
    logic [WORDS-1:0][DATA_W-1:0] mem;
    logic                         busy;
    logic                         done;
    cmd_e                         cmd;
    logic [ADDR_W-1:0]            addr;
    logic [DATA_W-1:0]            mask;   // zeros mark bits to clear
    logic [CNT_W-1:0]             ticks;
    logic                         flag;
    logic                         supply_seen;
    logic [DATA_W-1:0]            rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [DATA_W-1:0] m;
    m = '1;
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.rdata = st_reg.mem[link.addr];
    // build clear mask for the requested granularity
    // bit byte word
    case (link.size)
      op_prog_bit: m[link.bit_sel] = link.wdata[link.bit_sel];
      op_prog_byte: begin
        if (link.byte_sel) m[15:8] = link.wdata[15:8];
        else m[7:0] = link.wdata[7:0];
      end
      op_prog_word: m = link.wdata;
      default: m = '1;
    endcase
    if (!st_reg.busy && link.req && link.cmd != cmd_idle) begin
      st_next.busy = 1'b1;
      st_next.cmd = link.cmd;
      st_next.addr = link.addr;
      st_next.mask = m;
      st_next.ticks = (link.cmd == cmd_erase) ? ERASE_TICKS : PROG_TICKS;
      st_next.supply_seen = supply_low;
    end else if (st_reg.busy) begin
      // flag flips on supply shift mid-program
      if (st_reg.cmd == cmd_prog && supply_low != st_reg.supply_seen) begin
        st_next.flag = ~st_reg.flag;
        st_next.supply_seen = supply_low;
      end
      // timing only advances on divided ticks, a stopped clock stalls
      if (link.tick) begin
        if (st_reg.ticks > 8'h01) begin
          st_next.ticks = st_reg.ticks - 8'h01;
        end else begin
          st_next.ticks = '0;
          st_next.busy = 1'b0;
          st_next.done = 1'b1;
          if (st_reg.cmd == cmd_erase) begin
            for (int i = 0; i < SEG_WORDS; i++) begin
              st_next.mem[{st_reg.addr[ADDR_W-1:SEG_W], SEG_W'(i)}] = '1;
            end
          end else begin
            st_next.mem[st_reg.addr] = st_reg.mem[st_reg.addr] & st_reg.mask;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; array powers up erased
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.mem <= '1;
      st_reg.mask <= '1;
      st_reg.cmd <= cmd_idle;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.busy = st_reg.busy;
  assign link.done = st_reg.done;
  assign link.rdata = st_reg.rdata;
  assign link.supply_shift_flag = st_reg.flag;
endmodule

// >>> core/flash_ctrl.sv
// controlling end: clock divider, range check, flag comparison
module flash_ctrl #(
  parameter logic [7:0] DIV = flash_pkg::DIV_DEFAULT
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // user side
  input  wire logic                   user_req,
  input  wire flash_pkg::cmd_e        user_cmd,
  input  wire flash_pkg::prog_size_e  user_size,
  input  wire logic [7:0]             user_addr,
  input  wire logic [3:0]             user_bit,
  input  wire logic                   user_byte,
  input  wire logic [15:0]            user_wdata,
  output logic                        user_busy,
  output logic                        user_done,
  output logic                        user_range_err,
  output logic                        user_corrupt,
  // link to array
  flash_if.ctrl                       link
);
  import flash_pkg::*;

  typedef struct packed {
    logic [7:0]         div;
    logic               tick;
    logic               req;
    cmd_e               cmd;
    prog_size_e         size;
    logic [ADDR_W-1:0]  addr;
    logic [3:0]         bsel;
    logic               bytes;
    logic [DATA_W-1:0]  wdata;
    logic               pend;
    logic               flag_start;
    logic               done;
    logic               err;
    logic               corrupt;
  } state_s;

  state_s st_reg;
  state_s st_next;

  ////////////////////////////////////////////////////////////////////////
  // next state; strobes fall back to zero unless set below
  always_comb begin
    st_next = st_reg;
    st_next.req = 1'b0;
    st_next.done = 1'b0;
    st_next.err = 1'b0;
    st_next.tick = (st_reg.div == DIV);
    st_next.div = (st_reg.div == DIV) ? DIV_RESET : st_reg.div + 8'h01;
    if (user_req && !st_reg.pend) begin
      if (user_addr >= 8'(WORDS)) begin
        st_next.err = 1'b1;
      end else begin
        st_next.req = 1'b1;
        st_next.pend = 1'b1;
        st_next.cmd = user_cmd;
        st_next.size = user_size;
        st_next.addr = user_addr[ADDR_W-1:0];
        st_next.bsel = user_bit;
        st_next.bytes = user_byte;
        st_next.wdata = user_wdata;
        st_next.flag_start = link.supply_shift_flag;
      end
    end
    if (link.done) begin
      st_next.pend = 1'b0;
      st_next.done = 1'b1;
      st_next.corrupt = (st_reg.cmd == cmd_prog) &&
                        (link.supply_shift_flag != st_reg.flag_start);
    end
  end

  // registers; link strobes idle low out of reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.cmd <= cmd_idle;
      st_reg.size <= op_none;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.req = st_reg.req;
  assign link.cmd = st_reg.cmd;
  assign link.size = st_reg.size;
  assign link.addr = st_reg.addr;
  assign link.bit_sel = st_reg.bsel;
  assign link.byte_sel = st_reg.bytes;
  assign link.wdata = st_reg.wdata;
  assign link.tick = st_reg.tick;
  assign user_busy = st_reg.pend;
  assign user_done = st_reg.done;
  assign user_range_err = st_reg.err;
  assign user_corrupt = st_reg.corrupt;
endmodule

// >>> testbench/flash_segment_erase_write_props.sv
// timing checks on the link between controller and flash array
module flash_props
  import flash_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // link signals
  input wire logic req,
  input wire cmd_e cmd,
  input wire prog_size_e size,
  input wire logic tick,
  input wire logic busy,
  input wire logic done,
  input wire logic supply_shift_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // a real request always starts an operation
  req_starts_busy_a: assert property (
    req && !busy && (cmd == cmd_erase || (cmd == cmd_prog && size != op_none)) |=> busy)
    else $error("no busy");
  // busy and done are registered together, so busy falls on the edge done rises
  busy_holds_a: assert property (busy |=> busy || done) else $error("busy dropped");
  busy_min_len_a: assert property ($rose(busy) |-> busy[*8]) else $error("busy short");
  busy_bounded_a: assert property ($rose(busy) |-> ##[1:80] done) else $error("no done");
  done_one_cycle_a: assert property (done |=> !done) else $error("done long");
  done_after_busy_a: assert property (done |-> $past(busy)) else $error("stray done");
  // the controller never offers a request to a busy array
  req_idle_only_a: assert property (req |-> !busy) else $error("req while busy");
  // gaps between ticks keep the timing generator in range
  tick_spacing_a: assert property (tick && busy |=> !tick[*3]) else $error("tick fast");
  flag_in_op_a: assert property ($changed(supply_shift_flag) |-> $past(busy))
    else $error("flag moved idle");
  ////////////////////////////////////////////////////////////////
  cover property (req && cmd == cmd_erase);
  cover property (req && size == op_prog_bit);
  cover property ($changed(supply_shift_flag));
endmodule

// >>> testbench/flash_segment_erase_write_bench.sv
// self-checking bench: controller and array joined, user side driven
module flash_segment_erase_write_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_pkg::*;
  logic sys_clk = 0, nrst = 0, user_req = 0, user_byte = 0, supply_low = 0;
  cmd_e user_cmd = cmd_idle;
  prog_size_e user_size = op_none;
  logic [7:0] user_addr = 8'h00;
  logic [3:0] user_bit = 4'h0;
  logic [15:0] user_wdata = 16'h0000;
  logic user_busy, user_done, user_range_err, user_corrupt;
  logic [15:0] mem [64];
  logic [31:0] r;
  logic [15:0] w;
  int num_errors = 0, num_checks = 0, cyc = 0, seed = 32'h2780, i, n;
  flash_if link();
  flash_ctrl #(.DIV(8'h03)) u_flash_ctrl (.sys_clk, .nrst, .user_req, .user_cmd,
    .user_size, .user_addr, .user_bit, .user_byte, .user_wdata, .user_busy,
    .user_done, .user_range_err, .user_corrupt, .link);
  flash_array u_flash_array (.sys_clk, .nrst, .link, .supply_low);
  flash_props u_flash_props (.sys_clk, .nrst, .req(link.req), .cmd(link.cmd),
    .size(link.size), .tick(link.tick), .busy(link.busy), .done(link.done),
    .supply_shift_flag(link.supply_shift_flag));
  ////////////////////////////////////////////////////////////////
  always #50 sys_clk = ~sys_clk;
  // hang guard, well above the longest run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // expected word after a clear-only program of one size
  function automatic logic [15:0] prog_exp(input logic [15:0] old, input prog_size_e z,
                                           input logic [3:0] b, input logic y,
                                           input logic [15:0] d);
    logic [15:0] m;
    m = 16'hffff;
    if (z == op_prog_word) m = d;
    else if (z == op_prog_byte) m = y ? {d[15:8], 8'hff} : {8'hff, d[7:0]};
    else if (z == op_prog_bit) m[b] = d[b];
    return old & m;
  endfunction
  // one operation; model updated, then word read back on rdata
  task op(cmd_e c, prog_size_e z, logic [7:0] a, logic [3:0] b, logic y,
          logic [15:0] d, logic g);
    @(posedge sys_clk);
    {user_cmd, user_size, user_addr} <= {c, z, a};
    {user_bit, user_byte, user_wdata, user_req} <= {b, y, d, 1'b1};
    @(posedge sys_clk);
    user_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({15'h0, user_busy}, 16'h0001);
    // a stray erase while busy must leave the array alone
    {user_cmd, user_req} <= {cmd_erase, 1'b1};
    supply_low <= supply_low ^ g; // supply shift made while busy, left shifted afterwards
    @(posedge sys_clk);
    user_req <= 1'b0;
    n = 0;
    while (user_done !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0, user_done}, 16'h0001);
    // model of erase and clear-only program
    if (c == cmd_erase) for (i = 0; i < 8; i++) mem[{a[5:3], i[2:0]}] = 16'hffff;
    else mem[a[5:0]] = prog_exp(mem[a[5:0]], z, b, y, d);
    chk({15'h0, user_corrupt}, {15'h0, g});
    repeat (2) @(negedge sys_clk);
    chk(link.rdata, mem[a[5:0]]);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    for (i = 0; i < 64; i++) mem[i] = 16'hffff;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    // repeated programs of every size accumulate
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      op(cmd_prog, prog_size_e'(k % 3 + 1), {2'b00, r[5:0]}, r[9:6], r[10], r[31:16], 0);
      op(cmd_prog, op_prog_word, {2'b00, r[5:0]}, 4'h0, 1'b0, 16'h5a5a, 0);
    end
    $display("program tests done");
    // erase then read a neighbour in the same segment
    op(cmd_prog, op_prog_word, 8'h1a, 4'h0, 1'b0, 16'h0000, 0);
    op(cmd_erase, op_none, 8'h1d, 4'h0, 1'b0, 16'h0000, 0);
    op(cmd_prog, op_prog_word, 8'h1a, 4'h0, 1'b0, 16'hffff, 0);
    // row refresh: keep a word, erase its segment first, then write it back
    r = $random(seed);
    op(cmd_prog, op_prog_word, 8'h2b, 4'h0, 1'b0, r[15:0], 0);
    w = mem[6'h2b];
    op(cmd_erase, op_none, 8'h2b, 4'h0, 1'b0, 16'h0000, 0);
    op(cmd_prog, op_prog_word, 8'h2b, 4'h0, 1'b0, w, 0);
    chk(link.rdata, w);
    $display("erase tests done");
    // out of range address must be refused
    @(posedge sys_clk);
    {user_addr, user_cmd, user_req} <= {8'h40, cmd_prog, 1'b1};
    @(posedge sys_clk);
    user_req <= 1'b0;
    n = 0;
    while (user_range_err !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0, user_range_err}, 16'h0001);
    $display("range test done");
    // supply shift mid program, held, then a clean one
    op(cmd_prog, op_prog_word, 8'h05, 4'h0, 1'b0, 16'hf0f0, 1);
    op(cmd_prog, op_prog_word, 8'h05, 4'h0, 1'b0, 16'hff00, 0);
    $display("supply tests done");
    wrap_up();
  end
endmodule
